// [verilog/psb_pkg.sv]
// shared constants of the frame decoder and its command controller
package psb_pkg;
    // ------------------------------------------------------------
    // frame layout
    // ------------------------------------------------------------
    localparam int FRAME_BITS = 16;
    localparam int CMD_RW_BIT = 15;
    localparam int CMD_SPACE_BIT = 14;
    localparam int CMD_ADDR_MSB = 13;
    localparam int CMD_ADDR_LSB = 9;
    localparam int CMD_PAR_BIT = 8;
    localparam int CMD_DATA_MSB = 7;
    localparam logic CMD_READ = 1'b0;
    localparam logic CMD_WRITE = 1'b1;
    localparam logic SPACE_MAIN = 1'b0;
    localparam logic SPACE_FS = 1'b1;

    // ------------------------------------------------------------
    // global flag groups, index = response bit minus eight
    // ------------------------------------------------------------
    localparam int NUM_GRP = 8;
    localparam int DET_W = 15;
    localparam int G_VOTH = 0;
    localparam int G_VCORE = 1;
    localparam int G_VPRE = 2;
    localparam int G_IO = 3;
    localparam int G_LIN = 4;
    localparam int G_CAN = 5;
    localparam int G_WU = 6;
    localparam int G_SPI = 7;
    // main-space address of each group's diagnostic register
    localparam logic [4:0] GRP_ADDR [NUM_GRP] =
        '{5'h10, 5'h0F, 5'h0E, 5'h0B, 5'h12, 5'h11, 5'h09, 5'h13};
    // communication error detail bits, fail-safe copies sit above
    localparam int SPI_ERR_CLK = 0;
    localparam int SPI_ERR_PAR = 1;
    localparam int SPI_ERR_REQ = 2;
    localparam int SPI_FS_OFS = 3;

    // ------------------------------------------------------------
    // controller registers on the AHB-Lite side
    // ------------------------------------------------------------
    localparam logic [3:0] HOST_CMD_OFS = 4'h0;
    localparam logic [3:0] HOST_STAT_OFS = 4'h4;
    localparam logic [3:0] HOST_RESP_OFS = 4'h8;
    localparam int HCMD_RW_BIT = 14;
    localparam int HCMD_SPACE_BIT = 13;
    localparam int HCMD_ADDR_LSB = 8;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
    localparam logic [14:0] HCMD_RST = 15'h0000;
    localparam logic [15:0] HRESP_RST = 16'h0000;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CORE_CLK_NS = 8;
    localparam int FS_GAP_NS = 3500;
    localparam int FS_GAP_CYC = (FS_GAP_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
    localparam int SCLK_HALF_CYC = 8;
    localparam int CS_IDLE_CYC = 8;
endpackage

// [verilog/psb_spi_if.sv]
// four-wire link between the command controller and the frame decoder
`timescale 1ns/1ps
interface psb_spi_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic miso_bus;

    // undriven line is pulled low
    assign miso_bus = miso_oe ? miso : 1'b0;

    modport dev (
        input sclk,
        input cs_n,
        input mosi,
        output miso,
        output miso_oe
    );
    modport host (
        output sclk,
        output cs_n,
        output mosi,
        input miso_bus
    );
endinterface

// [verilog/psb_sync.sv]
// two-stage synchroniser for levels entering the core clock domain
`timescale 1ns/1ps
module psb_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            meta_q <= RST;
            q_o <= RST;
        end else if (ce_i) begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule

// [verilog/psb_dev.sv]
// frame decoder and global status reporting of the slave end
`timescale 1ns/1ps
module psb_dev
    import psb_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    psb_spi_if.dev spi,
    input wire logic [6:0] wu_evt_i,
    input wire logic [7:0] can_evt_i,
    input wire logic [3:0] lin_evt_i,
    input wire logic [5:0] io_evt_i,
    input wire logic [8:0] vpre_evt_i,
    input wire logic [4:0] vcore_evt_i,
    input wire logic [14:0] voth_evt_i,
    output logic wr_stb_o,
    output logic wr_space_o,
    output logic [4:0] wr_addr_o,
    output logic [7:0] wr_data_o,
    output logic [7:0] gflags_o
);
    localparam int PEEK = FRAME_BITS / 2;

    // ------------------------------------------------------------
    // link domain: receive on falling, send on rising edge
    // ------------------------------------------------------------
    logic arm_rx_q;
    logic arm_tx_q;
    logic frm_tgl_q;
    logic [4:0] rx_cnt_q;
    logic [15:0] rx_q;
    logic [3:0] tx_cnt_q;
    logic [3:0] tx_idx;
    logic [7:0] low_q;
    logic [7:0] low_byte;
    logic miso_q;
    logic tx_bit;

    // core-side images, held still while chip select is low
    logic [7:0] reg_q [64];
    logic [DET_W-1:0] dsnap_q [NUM_GRP];
    logic [7:0] gsnap_q;

    // chip select high presets the arm flags; no clock is needed
    always_ff @(negedge spi.sclk or posedge spi.cs_n) begin
        if (spi.cs_n) begin
            arm_rx_q <= 1'b1;
        end else begin
            arm_rx_q <= 1'b0;
        end
    end

    always_ff @(posedge spi.sclk or posedge spi.cs_n) begin
        if (spi.cs_n) begin
            arm_tx_q <= 1'b1;
        end else begin
            arm_tx_q <= 1'b0;
        end
    end

    always_ff @(negedge spi.sclk) begin
        rx_q <= {rx_q[14:0], spi.mosi};
    end

    // count and toggle must be defined before the first frame
    always_ff @(negedge spi.sclk or posedge reset_i) begin
        if (reset_i) begin
            rx_cnt_q <= 5'h00;
            frm_tgl_q <= 1'b0;
        end else if (arm_rx_q) begin
            rx_cnt_q <= 5'h01;
            frm_tgl_q <= ~frm_tgl_q;
        end else if (rx_cnt_q != 5'h1F) begin
            rx_cnt_q <= rx_cnt_q + 5'h01;
        end
    end

    assign tx_idx = arm_tx_q ? 4'h0 : tx_cnt_q;

    // eight bits in, rx_q[7:0] holds command bits 15..8
    always_comb begin
        low_byte = reg_q[rx_q[CMD_SPACE_BIT-PEEK:CMD_ADDR_LSB-PEEK]];
        if (rx_q[CMD_RW_BIT-PEEK] == CMD_WRITE) begin
            low_byte = dsnap_q[G_SPI][7:0];
        end else if (rx_q[CMD_SPACE_BIT-PEEK] == SPACE_MAIN) begin
            for (int g = 0; g < NUM_GRP; g++) begin
                if (rx_q[CMD_ADDR_MSB-PEEK:CMD_ADDR_LSB-PEEK] == GRP_ADDR[g])
                begin
                    low_byte = dsnap_q[g][7:0];
                end
            end
        end
    end

    always_comb begin
        if (!tx_idx[3]) begin
            tx_bit = gsnap_q[~tx_idx[2:0]];
        end else if (tx_idx == 4'h8) begin
            tx_bit = low_byte[7];
        end else begin
            tx_bit = low_q[~tx_idx[2:0]];
        end
    end

    always_ff @(posedge spi.sclk) begin
        tx_cnt_q <= (tx_idx == 4'hF) ? tx_idx : tx_idx + 4'h1;
        if (tx_idx == 4'h8) begin
            low_q <= low_byte;
        end
        miso_q <= tx_bit;
    end

    assign spi.miso = miso_q;
    assign spi.miso_oe = ~spi.cs_n;

    // ------------------------------------------------------------
    // core domain: frame end seen as synchronised chip select rise
    // ------------------------------------------------------------
    logic cs_s;
    logic tgl_s;
    logic cs_prev_q;
    logic tgl_seen_q;
    logic frame_end;
    logic len_ok;
    logic par_ok;
    logic wr_ok;
    logic rd_ok;
    logic req_err;
    logic [2:0] err_bits;
    logic [DET_W-1:0] det_q [NUM_GRP];
    logic [DET_W-1:0] evt_w [NUM_GRP];
    logic [5:0] spi_evt;

    psb_sync #(.W(2), .RST(2'h3)) u_sync (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .d_i({spi.cs_n, frm_tgl_q}),
        .q_o({cs_s, tgl_s})
    );
    // link registers are quiet while chip select is high
    assign frame_end = cs_s & ~cs_prev_q;
    assign len_ok = (tgl_s != tgl_seen_q) &&
        (rx_cnt_q == 5'(FRAME_BITS));
    assign par_ok = ^rx_q;
    assign wr_ok = len_ok && rx_q[CMD_RW_BIT] == CMD_WRITE && par_ok;
    assign req_err = len_ok && rx_q[CMD_RW_BIT] == CMD_READ &&
        rx_q[CMD_PAR_BIT:0] != 9'h000;
    assign rd_ok = len_ok && rx_q[CMD_RW_BIT] == CMD_READ && !req_err;
    assign err_bits[SPI_ERR_CLK] = !len_ok;
    assign err_bits[SPI_ERR_PAR] = len_ok && rx_q[CMD_RW_BIT] == CMD_WRITE &&
        !par_ok;
    assign err_bits[SPI_ERR_REQ] = req_err;
    // error lands in the space that the frame addressed
    assign spi_evt = !frame_end ? 6'h00 :
        (rx_q[CMD_SPACE_BIT] == SPACE_FS) ? {err_bits, 3'h0} :
        {3'h0, err_bits};

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            cs_prev_q <= 1'b1;
            tgl_seen_q <= 1'b0;
            wr_stb_o <= 1'b0;
            wr_space_o <= 1'b0;
            wr_addr_o <= 5'h00;
            wr_data_o <= 8'h00;
        end else if (ce_i) begin
            cs_prev_q <= cs_s;
            wr_stb_o <= frame_end && wr_ok;
            if (frame_end) begin
                tgl_seen_q <= tgl_s;
            end
            if (frame_end && wr_ok) begin
                wr_space_o <= rx_q[CMD_SPACE_BIT];
                wr_addr_o <= rx_q[CMD_ADDR_MSB:CMD_ADDR_LSB];
                wr_data_o <= rx_q[CMD_DATA_MSB:0];
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            for (int i = 0; i < 64; i++) begin
                reg_q[i] <= 8'h00;
            end
        end else if (ce_i && frame_end && wr_ok) begin
            reg_q[rx_q[CMD_SPACE_BIT:CMD_ADDR_LSB]] <=
                rx_q[CMD_DATA_MSB:0];
        end
    end

    assign evt_w[G_WU] = DET_W'(wu_evt_i);
    assign evt_w[G_CAN] = DET_W'(can_evt_i);
    assign evt_w[G_LIN] = DET_W'(lin_evt_i);
    assign evt_w[G_IO] = DET_W'(io_evt_i);
    assign evt_w[G_VPRE] = DET_W'(vpre_evt_i);
    assign evt_w[G_VCORE] = DET_W'(vcore_evt_i);
    assign evt_w[G_VOTH] = voth_evt_i;
    assign evt_w[G_SPI] = DET_W'(spi_evt);

    // ------------------------------------------------------------
    // sticky detail bits and their global OR per group
    // ------------------------------------------------------------
    for (genvar g = 0; g < NUM_GRP; g++) begin : g_grp
        logic hit;
        assign hit = frame_end && rd_ok &&
            rx_q[CMD_SPACE_BIT] == SPACE_MAIN &&
            rx_q[CMD_ADDR_MSB:CMD_ADDR_LSB] == GRP_ADDR[g];

        // only snapshot bits are cleared, the unsent ones above bit 7 too; a new event wins
        always_ff @(posedge core_clk_i) begin
            if (reset_i) begin
                det_q[g] <= '0;
            end else if (ce_i) begin
                det_q[g] <= (det_q[g] & ~(hit ? dsnap_q[g] : '0)) |
                    evt_w[g];
            end
        end

        always_ff @(posedge core_clk_i) begin
            if (reset_i) begin
                dsnap_q[g] <= '0;
                gsnap_q[g] <= 1'b0;
                gflags_o[g] <= 1'b0;
            end else if (ce_i) begin
                gflags_o[g] <= |det_q[g];
                if (cs_s && cs_prev_q) begin
                    dsnap_q[g] <= det_q[g];
                    gsnap_q[g] <= |det_q[g];
                end
            end
        end
    end
endmodule

// [verilog/psb_host.sv]
// command controller: master end of the link, run from AHB-Lite
`timescale 1ns/1ps
module psb_host
    import psb_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    psb_spi_if.host spi
);
    typedef enum logic [2:0] {
        H_IDLE, H_WAIT_GAP, H_LEAD, H_HIGH, H_LOW, H_TRAIL, H_REST
    } psb_hstate_t;

    psb_hstate_t state_q;
    logic [14:0] cmd_q;
    logic [15:0] resp_q;
    logic [15:0] tx_q;
    logic [3:0] bit_q;
    logic [8:0] tmr_q;
    logic [8:0] gap_q;
    logic busy_q;
    logic done_q;
    logic done_set;
    logic ap_valid_q;
    logic ap_write_q;
    logic [3:0] ap_addr_q;
    logic miso_s;
    logic cmd_wr;
    logic stat_wr;
    logic [7:0] tx_data;
    logic [15:0] frame;
    logic unused;

    assign unused = ^{haddr_i[31:4], hsize_i, htrans_i[0]};

    // ------------------------------------------------------------
    // AHB-Lite slave, zero wait states, always OKAY
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            ap_valid_q <= 1'b0;
            ap_write_q <= 1'b0;
            ap_addr_q <= 4'h0;
            hrdata_o <= 32'h00000000;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else if (ce_i) begin
            if (hready_i) begin
                ap_valid_q <= hsel_i && htrans_i[1];
                ap_write_q <= hwrite_i;
                ap_addr_q <= haddr_i[3:0];
                hrdata_o <= 32'h00000000;
                if (hsel_i && htrans_i[1] && !hwrite_i) begin
                    case (haddr_i[3:0])
                        HOST_CMD_OFS: hrdata_o <= 32'(cmd_q);
                        HOST_STAT_OFS: hrdata_o <= {30'h0, done_q, busy_q};
                        HOST_RESP_OFS: hrdata_o <= 32'(resp_q);
                        default: hrdata_o <= 32'h00000000;
                    endcase
                end
            end
        end
    end

    // a command arriving while busy is dropped
    assign cmd_wr = ap_valid_q && ap_write_q && ap_addr_q == HOST_CMD_OFS &&
        !busy_q;
    assign stat_wr = ap_valid_q && ap_write_q && ap_addr_q == HOST_STAT_OFS;
    assign done_set = state_q == H_REST && tmr_q == 9'h000;

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            done_q <= 1'b0;
        end else if (ce_i) begin
            if (done_set) begin
                done_q <= 1'b1;
            end else if (stat_wr && hwdata_i[STAT_DONE_BIT]) begin
                done_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // frame assembly
    // ------------------------------------------------------------
    assign tx_data = (cmd_q[HCMD_RW_BIT] == CMD_WRITE) ?
        cmd_q[7:0] : 8'h00;
    always_comb begin
        frame = {cmd_q[HCMD_RW_BIT:HCMD_ADDR_LSB], 1'b0, tx_data};
        if (cmd_q[HCMD_RW_BIT] == CMD_WRITE) begin
            frame[CMD_PAR_BIT] = ~^frame;
        end
    end

    psb_sync #(.W(1), .RST(1'b0)) u_miso_sync (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .d_i(spi.miso_bus),
        .q_o(miso_s)
    );

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            gap_q <= 9'h000;
        end else if (ce_i) begin
            if (state_q == H_TRAIL && tmr_q == 9'h000 &&
                cmd_q[HCMD_SPACE_BIT] == SPACE_FS) begin
                gap_q <= 9'(FS_GAP_CYC);
            end else if (gap_q != 9'h000 && spi.cs_n) begin
                // only select-high time counts; main frames may sit inside
                gap_q <= gap_q - 9'h001;
            end
        end
    end

    // ------------------------------------------------------------
    // link sequencer: clock made by dividing the core clock
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            state_q <= H_IDLE;
            cmd_q <= HCMD_RST;
            resp_q <= HRESP_RST;
            tx_q <= 16'h0000;
            bit_q <= 4'h0;
            tmr_q <= 9'h000;
            busy_q <= 1'b0;
            spi.sclk <= 1'b0;
            spi.cs_n <= 1'b1;
            spi.mosi <= 1'b0;
        end else if (ce_i) begin
            if (tmr_q != 9'h000) begin
                tmr_q <= tmr_q - 9'h001;
            end
            case (state_q)
                H_IDLE: begin
                    if (cmd_wr) begin
                        cmd_q <= hwdata_i[14:0];
                        busy_q <= 1'b1;
                        state_q <= H_WAIT_GAP;
                    end
                end
                H_WAIT_GAP: begin
                    if (cmd_q[HCMD_SPACE_BIT] == SPACE_MAIN ||
                        gap_q == 9'h000) begin
                        spi.cs_n <= 1'b0;
                        tx_q <= frame;
                        bit_q <= 4'h0;
                        tmr_q <= 9'(SCLK_HALF_CYC - 1);
                        state_q <= H_LEAD;
                    end
                end
                H_LEAD, H_LOW: begin
                    if (tmr_q == 9'h000) begin
                        spi.sclk <= 1'b1;
                        spi.mosi <= tx_q[15];
                        tx_q <= {tx_q[14:0], 1'b0};
                        tmr_q <= 9'(SCLK_HALF_CYC - 1);
                        state_q <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    if (tmr_q == 9'h000) begin
                        spi.sclk <= 1'b0;
                        resp_q <= {resp_q[14:0], miso_s};
                        bit_q <= bit_q + 4'h1;
                        tmr_q <= 9'(SCLK_HALF_CYC - 1);
                        state_q <= (bit_q == 4'hF) ? H_TRAIL : H_LOW;
                    end
                end
                H_TRAIL: begin
                    if (tmr_q == 9'h000) begin
                        spi.cs_n <= 1'b1;
                        tmr_q <= 9'(CS_IDLE_CYC - 1);
                        state_q <= H_REST;
                    end
                end
                H_REST: begin
                    if (tmr_q == 9'h000) begin
                        busy_q <= 1'b0;
                        state_q <= H_IDLE;
                    end
                end
                default: begin
                    state_q <= H_IDLE;
                end
            endcase
        end
    end
endmodule

// [test/psb_spi_sva.sv]
// link checker between the command controller and the frame decoder
`timescale 1ns/1ps
module psb_spi_sva
    import psb_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic miso_bus
);
    logic sclk_q;
    logic [4:0] nbit_q;
    logic [15:0] frm_q;
    int gap_q;

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    always_ff @(posedge core_clk_i) begin
        sclk_q <= reset_i ? 1'b0 : sclk;
    end
    // frame rebuilt from mosi at each falling link clock
    always_ff @(posedge core_clk_i) begin
        if (reset_i || cs_n) begin
            nbit_q <= 5'h00;
        end else if (sclk_q && !sclk) begin
            nbit_q <= nbit_q + 5'h01;
            frm_q <= {frm_q[14:0], mosi};
        end
    end
    // cs high cycles since the last fail-safe frame, saturating
    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            gap_q <= FS_GAP_CYC;
        end else if ($rose(cs_n) && frm_q[14]) begin
            gap_q <= 0;
        end else if (cs_n && gap_q < FS_GAP_CYC) begin
            gap_q <= gap_q + 1;
        end
    end

    oe_tracks_cs_a: assert property (miso_oe == !cs_n)
        else $error("miso enable differs from select");
    sclk_idle_a: assert property (cs_n |-> !sclk)
        else $error("link clock moves outside a frame");
    cs_setup_a: assert property ($fell(cs_n) |-> !sclk [*4])
        else $error("link clock too soon after select");
    bit_count_a: assert property ($rose(cs_n) |-> nbit_q == 5'h10)
        else $error("frame without sixteen clocks");
    mosi_hold_a: assert property (!cs_n && !$past(cs_n) && !$rose(sclk)
        |-> $stable(mosi))
        else $error("mosi changed away from rising clock");
    miso_hold_a: assert property (!cs_n && !$past(cs_n) && !$rose(sclk)
        |-> $stable(miso_bus))
        else $error("miso changed away from rising clock");
    write_parity_a: assert property ($rose(cs_n) && frm_q[15]
        |-> ^frm_q)
        else $error("write frame with even ones count");
    read_zero_a: assert property ($rose(cs_n) && !frm_q[15]
        |-> frm_q[8:0] == 9'h000)
        else $error("read frame with nonzero low bits");
    fs_gap_a: assert property ($rose(cs_n) && frm_q[14]
        |-> gap_q + 1 >= FS_GAP_CYC)
        else $error("fail-safe frames too close");
endmodule

// [test/tb_top.sv]
// self-checking bench: controller and decoder joined over the link
`timescale 1ns/1ps
`define CHK(a, b) begin \
    checked++; \
    if ((a) !== (b)) begin \
        miscompares++; \
        $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); \
    end \
end
module tb_top
    import psb_pkg::*;
;
    logic core_clk_i = 1'b0;
    logic reset_i;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic hready, hresp, wr_stb, wr_space, wr_stb2, wr_space2;
    logic [31:0] hrdata;
    logic [53:0] evt = 54'h0;
    logic [4:0] wr_addr, wr_addr2;
    logic [7:0] wr_data, wr_data2, gflags, gflags2;
    int checked = 0;
    int miscompares = 0;
    int wr_cnt = 0;
    int wr_cnt2 = 0;

    psb_spi_if link();
    psb_spi_if link2();

    always #4 core_clk_i = ~core_clk_i;

    psb_host psb_host_inst (.core_clk_i(core_clk_i), .reset_i(reset_i),
        .ce_i(1'b1), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
        .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp),
        .hrdata_o(hrdata), .spi(link));
    psb_dev psb_dev_inst (.core_clk_i(core_clk_i), .reset_i(reset_i),
        .ce_i(1'b1), .spi(link), .wu_evt_i(evt[6:0]),
        .can_evt_i(evt[14:7]), .lin_evt_i(evt[18:15]),
        .io_evt_i(evt[24:19]), .vpre_evt_i(evt[33:25]),
        .vcore_evt_i(evt[38:34]), .voth_evt_i(evt[53:39]),
        .wr_stb_o(wr_stb), .wr_space_o(wr_space), .wr_addr_o(wr_addr),
        .wr_data_o(wr_data), .gflags_o(gflags));
    // second decoder, fed by a bench master that can break the framing
    psb_dev psb_dev_inst_2 (.core_clk_i(core_clk_i), .reset_i(reset_i),
        .ce_i(1'b1), .spi(link2), .wu_evt_i(evt[6:0]),
        .can_evt_i(evt[14:7]), .lin_evt_i(evt[18:15]),
        .io_evt_i(evt[24:19]), .vpre_evt_i(evt[33:25]),
        .vcore_evt_i(evt[38:34]), .voth_evt_i(evt[53:39]),
        .wr_stb_o(wr_stb2), .wr_space_o(wr_space2), .wr_addr_o(wr_addr2),
        .wr_data_o(wr_data2), .gflags_o(gflags2));
    psb_spi_sva psb_spi_sva_inst (.core_clk_i(core_clk_i),
        .reset_i(reset_i), .sclk(link.sclk), .cs_n(link.cs_n),
        .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe),
        .miso_bus(link.miso_bus));

    initial begin
        link2.sclk = 1'b0;
        link2.cs_n = 1'b1;
        link2.mosi = 1'b0;
    end
    always @(posedge core_clk_i) begin
        if (wr_stb === 1'b1) wr_cnt <= wr_cnt + 1;
        if (wr_stb2 === 1'b1) wr_cnt2 <= wr_cnt2 + 1;
    end

    // ------------------------------------------------------------
    // bus and link tasks
    // ------------------------------------------------------------
    task automatic ahb(input logic w, input logic [3:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {28'h0, a};
        hwrite <= w;
        do @(posedge core_clk_i); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge core_clk_i); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic xfer(input logic [14:0] c, output logic [15:0] r);
        logic [31:0] d;
        int i;
        i = 0;
        ahb(1'b1, HOST_CMD_OFS, {17'h0, c}, d);
        do begin
            ahb(1'b0, HOST_STAT_OFS, 32'h0, d);
            i++;
        end while (d[STAT_DONE_BIT] !== 1'b1 && i < 5000);
        if (i >= 5000) miscompares++;
        ahb(1'b1, HOST_STAT_OFS, 32'h2, d);
        ahb(1'b0, HOST_RESP_OFS, 32'h0, d);
        r = d[15:0];
    endtask
    // link clock made here runs only inside the frame, 125 ns period
    task automatic send2(input logic [15:0] f, input int n,
                         output logic [15:0] r);
        r = 16'h0;
        link2.cs_n = 1'b0;
        #100;
        for (int i = 0; i < n; i++) begin
            link2.sclk = 1'b1;
            link2.mosi = f[15 - i];
            #62.5;
            r = {r[14:0], link2.miso_bus};
            link2.sclk = 1'b0;
            #62.5;
        end
        #100;
        link2.cs_n = 1'b1;
        link2.mosi = 1'b0;
        #300;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic s_link;
        logic [15:0] r;
        logic [31:0] d;
        xfer({1'b1, 1'b0, 5'h05, 8'hA5}, r);
        `CHK({wr_space, wr_addr, wr_data}, 14'h05A5);
        `CHK(r[15:8], 8'h00);
        ahb(1'b1, 4'hC, 32'hFFFFFFFF, d);
        ahb(1'b0, 4'hC, 32'h0, d);
        `CHK({hresp, d}, 33'h0);
        xfer({1'b1, 1'b1, 5'h06, 8'h3C}, r);
        `CHK({wr_space, wr_addr, wr_data}, 14'h263C);
        xfer({1'b1, 1'b1, 5'h07, 8'hC3}, r);
        `CHK(wr_cnt, 3);
        xfer({1'b0, 1'b0, 5'h05, 8'h00}, r);
        `CHK(r[7:0], 8'hA5);
        xfer({1'b0, 1'b1, 5'h06, 8'h00}, r);
        `CHK({r[7:0], 8'(wr_cnt)}, 16'h3C03);
    endtask
    task automatic s_flags;
        int pos [2][7] = '{'{53, 38, 33, 24, 18, 14, 6},
                           '{39, 34, 25, 19, 15, 7, 0}};
        logic [15:0] r;
        for (int j = 0; j < 2; j++) begin
            for (int g = 0; g < 7; g++) begin
                @(posedge core_clk_i);
                evt[pos[j][g]] <= 1'b1;
                @(posedge core_clk_i);
                evt <= 54'h0;
                repeat (4) @(posedge core_clk_i);
                `CHK(gflags, 8'(1 << g));
                repeat (36) @(posedge core_clk_i);
                `CHK(gflags, 8'(1 << g));
                xfer({1'b0, 1'b0, GRP_ADDR[g], 8'h00}, r);
                `CHK(r[15:8], 8'(1 << g));
                if (j == 1) `CHK(r[7:0], 8'h01);
                repeat (4) @(posedge core_clk_i);
                `CHK(gflags, 8'h00);
            end
        end
    endtask
    task automatic s_faults;
        logic [15:0] f [3] = '{16'h8E11, 16'h0A00, 16'h4A01};
        int n [3] = '{16, 15, 16};
        int b [3] = '{SPI_ERR_PAR, SPI_ERR_CLK, SPI_FS_OFS + SPI_ERR_REQ};
        logic [15:0] r;
        int w;
        w = wr_cnt2;
        for (int k = 0; k < 3; k++) begin
            send2(f[k], n[k], r);
            `CHK(gflags2[G_SPI], 1'b1);
            send2(16'h2600, 16, r);
            `CHK({r[15], r[7:0]}, {1'b1, 8'(1 << b[k])});
            `CHK(gflags2[G_SPI], 1'b0);
        end
        `CHK(wr_cnt2, w);
        send2(16'h8F11, 16, r);
        `CHK({wr_space2, wr_addr2, wr_data2}, 14'h0711);
        send2(16'h0E00, 16, r);
        `CHK(r[7:0], 8'h11);
    endtask

    task end_sim;
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        // a real rising edge, so the link-side clears fire
        reset_i <= 1'b1;
        repeat (10) @(posedge core_clk_i);
        reset_i <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        `CHK({gflags, gflags2}, 16'h0000);
        s_link;
        s_flags;
        s_faults;
        end_sim;
    end
    initial begin
        #400000;
        miscompares++;
        end_sim;
    end
endmodule
